// >>> rtl/dsh_cmd_core.sv
// Sleep and health-monitoring command interpreter of a drive
`timescale 1ns/1ps
`default_nettype none
module dsh_cmd_core (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic softReset,
    input wire logic comReset,
    input wire logic cmdValid,
    input wire dsh_pkg::dsh_cmd_t cmdIn,
    output logic cmdReady,
    output logic flushReq,
    input wire logic flushDone,
    output logic spinDownReq,
    input wire logic spinDone,
    input wire logic spindleStopped,
    output logic commitReq,
    input wire logic commitDone,
    output logic fetchReq,
    input wire logic fetchDone,
    output logic linkActive,
    output logic dataValid,
    output logic [15:0] dataWord,
    input wire logic dataTake,
    input wire dsh_pkg::dsh_reg_req_t regReq,
    output logic [31:0] regRdata,
    output logic irq
);
    import dsh_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_FLUSH,
        ST_SPIN,
        ST_ASLEEP,
        ST_COMMIT,
        ST_FETCH,
        ST_LOAD,
        ST_XFER,
        ST_OTHER
    } dsh_state_t;

    dsh_state_t state;
    dsh_state_t next_state;
    dsh_cmd_t cmd;
    dsh_cmd_t next_cmd;
    logic [7:0] errFlags;
    logic [7:0] next_errFlags;
    logic [7:0] statFlags;
    logic [7:0] next_statFlags;
    logic [31:0] next_regRdata;
    logic [2:0] irqEvents;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [2:0] irqClear;
    logic blockLoad;
    logic lastWord;
    logic wakeUp;
    logic cmdTaken;
    logic keysOk;
    logic subOk;

    // ****************************************
    // Block data source
    // ****************************************
    dsh_block_src u_src (
        .mclk(mclk),
        .resetn(resetn),
        .load(blockLoad),
        .selThresh(cmd.feature == SUB_READ_THRESH),
        .take(dataTake && dataValid),
        .word(dataWord),
        .lastWord(lastWord)
    );

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    assign irqClear = (regReq.wr && regReq.addr == ADDR_IRQ_STAT) ? regReq.wdata[2:0] : 3'h0;

    dsh_irq u_irq (
        .mclk(mclk),
        .resetn(resetn),
        .events(irqEvents),
        .clearBits(irqClear),
        .maskIn(regReq.wdata[2:0]),
        .maskWr(regReq.wr && regReq.addr == ADDR_IRQ_MASK),
        .status(irqStatus),
        .mask(irqMask),
        .irq(irq)
    );

    // ****************************************
    // Handshake and side-effect outputs
    // ****************************************
    assign wakeUp = softReset || comReset;
    assign cmdReady = (state == ST_IDLE);
    assign flushReq = (state == ST_FLUSH);
    assign spinDownReq = (state == ST_SPIN);
    assign commitReq = (state == ST_COMMIT);
    assign fetchReq = (state == ST_FETCH);
    assign linkActive = (state != ST_ASLEEP);
    assign dataValid = (state == ST_XFER);
    assign blockLoad = (state == ST_LOAD);

    // ****************************************
    // Command acceptance terms
    // ****************************************
    assign cmdTaken = cmdValid && cmdReady;
    assign keysOk = (cmdIn.lbaMid == KEY_MID) && (cmdIn.lbaHigh == KEY_HIGH);
    assign subOk = sub_ok(cmdIn.feature);

    // ****************************************
    // Command sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_errFlags = errFlags;
        next_statFlags = statFlags;
        irqEvents = 3'h0;
        next_statFlags[ST_BSY_BIT] = 1'b0;
        next_statFlags[ST_DRQ_BIT] = 1'b0;
        unique case (state)
            // Waiting for a command
            ST_IDLE: begin
                if (cmdTaken) begin
                    next_cmd = cmdIn;
                    next_errFlags = 8'h00;
                    next_statFlags[ST_ERR_BIT] = 1'b0;
                    next_statFlags[ST_BSY_BIT] = 1'b1;
                    // Class of the offered opcode
                    unique case (classify(cmdIn.opcode))
                        CLS_SLEEP: begin
                            next_state = ST_FLUSH;
                        end
                        CLS_HEALTH: begin
                            if (!keysOk || !subOk) begin
                                next_state = ST_OTHER;
                                next_errFlags[ERR_ABORT_BIT] = 1'b1;
                            end else if (cmdIn.feature == SUB_READ_ATTR) begin
                                next_state = ST_COMMIT;
                            end else if (cmdIn.feature == SUB_READ_THRESH) begin
                                next_state = ST_FETCH;
                            end else begin
                                next_state = ST_OTHER;
                            end
                        end
                        CLS_NONE: begin
                            next_state = ST_OTHER;
                        end
                    endcase
                end
            end

            // Cached writes being flushed
            ST_FLUSH: begin
                next_statFlags[ST_BSY_BIT] = 1'b1;
                if (flushDone) begin
                    next_state = spindleStopped ? ST_ASLEEP : ST_SPIN;
                    if (spindleStopped) begin
                        irqEvents[IRQ_SLEEP_BIT] = 1'b1;
                    end
                end
            end

            // Spindle being stopped
            ST_SPIN: begin
                next_statFlags[ST_BSY_BIT] = 1'b1;
                if (spinDone) begin
                    next_state = ST_ASLEEP;
                    irqEvents[IRQ_SLEEP_BIT] = 1'b1;
                end
            end

            // Interface idle until a reset
            ST_ASLEEP: begin
                if (wakeUp) begin
                    next_state = ST_IDLE;
                    next_errFlags = 8'h00;
                    next_statFlags[ST_ERR_BIT] = 1'b0;
                end
            end

            // Attribute values being committed
            ST_COMMIT: begin
                next_statFlags[ST_BSY_BIT] = 1'b1;
                if (commitDone) begin
                    next_state = ST_LOAD;
                end
            end

            // Thresholds being fetched
            ST_FETCH: begin
                next_statFlags[ST_BSY_BIT] = 1'b1;
                if (fetchDone) begin
                    next_state = ST_LOAD;
                end
            end

            // First block word being loaded
            ST_LOAD: begin
                next_statFlags[ST_BSY_BIT] = 1'b1;
                next_state = ST_XFER;
            end

            // Host taking block words
            ST_XFER: begin
                next_statFlags[ST_DRQ_BIT] = 1'b1;
                if (dataTake && lastWord) begin
                    next_state = ST_IDLE;
                    next_statFlags[ST_DRQ_BIT] = 1'b0;
                    irqEvents[IRQ_DONE_BIT] = 1'b1;
                end
            end

            // One-cycle completion of the rest
            ST_OTHER: begin
                // Completes at once; abort shown in both flag registers
                next_state = ST_IDLE;
                next_statFlags[ST_ERR_BIT] = errFlags[ERR_ABORT_BIT];
                irqEvents[IRQ_DONE_BIT] = 1'b1;
                irqEvents[IRQ_ABORT_BIT] = errFlags[ERR_ABORT_BIT];
            end
        endcase

        // Reset wakes nothing unless asleep; it also clears a busy command
        if (wakeUp && state != ST_ASLEEP) begin
            next_state = ST_IDLE;
        end
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cmd <= '0;
            errFlags <= 8'h00;
            statFlags <= STATUS_RESET;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            errFlags <= next_errFlags;
            statFlags <= next_statFlags;
        end
    end

    // ****************************************
    // Register read port, data one cycle later
    // ****************************************
    always_comb begin
        next_regRdata = 32'h0000_0000;
        if (regReq.rd) begin
            unique case (regReq.addr)
                ADDR_ERROR: begin
                    next_regRdata = {24'h0, errFlags};
                end
                ADDR_STATUS: begin
                    next_regRdata = {24'h0, statFlags};
                end
                ADDR_IRQ_STAT: begin
                    next_regRdata = {29'h0, irqStatus};
                end
                ADDR_IRQ_MASK: begin
                    next_regRdata = {29'h0, irqMask};
                end
                ADDR_STATE: begin
                    next_regRdata = {28'h0, state};
                end
                // Unmapped addresses read as zero
                default: next_regRdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data register, stands one cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= next_regRdata;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dsh_pkg.sv
// Package: opcodes, flags, register map and carrier types of the drive command block
package dsh_pkg;

    // ****************************************
    // Opcodes and keys
    // ****************************************
    localparam logic [7:0] OP_SLEEP_A = 8'he6;
    localparam logic [7:0] OP_SLEEP_B = 8'h99;
    localparam logic [7:0] OP_HEALTH = 8'hb0;
    localparam logic [7:0] KEY_MID = 8'h4f;
    localparam logic [7:0] KEY_HIGH = 8'hc2;

    // Subcommand codes
    localparam logic [7:0] SUB_READ_ATTR = 8'hd0;
    localparam logic [7:0] SUB_READ_THRESH = 8'hd1;
    localparam logic [7:0] SUB_LOW_FIRST = 8'hd0;
    localparam logic [7:0] SUB_LOW_LAST = 8'hd6;
    localparam logic [7:0] SUB_HIGH_FIRST = 8'hd8;
    localparam logic [7:0] SUB_HIGH_LAST = 8'hdb;

    // ****************************************
    // Flag positions
    // ****************************************
    localparam int ERR_ABORT_BIT = 2;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_DRQ_BIT = 3;
    localparam int ST_SEEK_BIT = 4;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_BSY_BIT = 7;
    // Ready and seek complete shown after reset
    localparam logic [7:0] STATUS_RESET = 8'h50;

    // ****************************************
    // Block transfer
    // ****************************************
    localparam int BLOCK_BYTES = 512;
    localparam int BLOCK_WORDS = 256;
    localparam logic [7:0] LAST_WORD = 8'hff;

    // ****************************************
    // Register map (byte address, word index = address / 4)
    // ****************************************
    localparam logic [7:0] ADDR_ERROR = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [1:0] IRQ_DONE_BIT = 2'd0;
    localparam logic [1:0] IRQ_ABORT_BIT = 2'd1;
    localparam logic [1:0] IRQ_SLEEP_BIT = 2'd2;

    // Task-file command as latched at issue
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] feature;
        logic [7:0] lbaMid;
        logic [7:0] lbaHigh;
    } dsh_cmd_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dsh_reg_req_t;

    typedef enum logic [1:0] {
        CLS_NONE,
        CLS_SLEEP,
        CLS_HEALTH
    } dsh_class_t;

    // Opcode decode, used by the interpreter only; the subcommand check does not call it
    function automatic dsh_class_t classify(input logic [7:0] op);
        if (op == OP_SLEEP_A || op == OP_SLEEP_B) begin
            return CLS_SLEEP;
        end else if (op == OP_HEALTH) begin
            return CLS_HEALTH;
        end
        return CLS_NONE;
    endfunction

    function automatic logic sub_ok(input logic [7:0] f);
        return (f >= SUB_LOW_FIRST && f <= SUB_LOW_LAST) ||
               (f >= SUB_HIGH_FIRST && f <= SUB_HIGH_LAST);
    endfunction

endpackage

// >>> rtl/dsh_irq.sv
// Sticky interrupt status with mask and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module dsh_irq (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] events,
    input wire logic [2:0] clearBits,
    input wire logic [2:0] maskIn,
    input wire logic maskWr,
    output logic [2:0] status,
    output logic [2:0] mask,
    output logic irq
);
    import dsh_pkg::*;

    logic [2:0] next_status;
    logic [2:0] next_mask;

    // ****************************************
    // Next values, set beats clear
    // ****************************************
    always_comb begin
        next_status = (status & ~clearBits) | events;
        next_mask = maskWr ? maskIn : mask;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status <= IRQ_RESET;
            mask <= IRQ_RESET;
        end else begin
            status <= next_status;
            mask <= next_mask;
        end
    end

    // A set mask bit holds its event back
    assign irq = |(status & ~mask);
endmodule
`default_nettype wire

// >>> rtl/dsh_block_src.sv
// Word source for 512-byte attribute and threshold blocks
`timescale 1ns/1ps
`default_nettype none
module dsh_block_src (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic load,
    input wire logic selThresh,
    input wire logic take,
    output logic [15:0] word,
    output logic lastWord
);
    import dsh_pkg::*;

    logic [15:0] attrMem [BLOCK_WORDS];
    logic [15:0] threshMem [BLOCK_WORDS];
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic sel;
    logic next_sel;
    logic [15:0] next_word;

    // ****************************************
    // Fixed block contents
    // ****************************************
    generate
        for (genvar i = 0; i < BLOCK_WORDS; i++) begin : g_fill
            assign attrMem[i] = {8'h00, 8'(i)};
            assign threshMem[i] = {8'h01, 8'(i)};
        end
    endgenerate

    // Index steps on each word taken by the host
    always_comb begin
        next_idx = idx;
        next_sel = sel;
        if (load) begin
            next_idx = 8'h00;
            next_sel = selThresh;
        end else if (take) begin
            next_idx = idx + 8'h01;
        end
        next_word = next_sel ? threshMem[next_idx] : attrMem[next_idx];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idx <= 8'h00;
            sel <= 1'b0;
            word <= 16'h0000;
        end else begin
            idx <= next_idx;
            sel <= next_sel;
            word <= next_word;
        end
    end

    assign lastWord = (idx == LAST_WORD);
endmodule
`default_nettype wire

// >>> verif/dsh_cmd_core_properties.sv
// Port checker of the drive command block
`timescale 1ns/1ps
`default_nettype none
module dsh_cmd_core_properties
    import dsh_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic softReset,
    input wire logic comReset,
    input wire logic cmdValid,
    input wire dsh_pkg::dsh_cmd_t cmdIn,
    input wire logic cmdReady,
    input wire logic flushReq,
    input wire logic flushDone,
    input wire logic spinDownReq,
    input wire logic spinDone,
    input wire logic spindleStopped,
    input wire logic commitReq,
    input wire logic commitDone,
    input wire logic fetchReq,
    input wire logic fetchDone,
    input wire logic linkActive,
    input wire logic dataValid,
    input wire logic [15:0] dataWord,
    input wire logic dataTake,
    input wire dsh_pkg::dsh_reg_req_t regReq,
    input wire logic [31:0] regRdata,
    input wire logic irq
);
    logic take;
    logic keys;
    logic hlth;
    // ****************************************
    // Command acceptance terms
    // ****************************************
    assign take = cmdValid && cmdReady;
    assign keys = cmdIn.lbaMid == KEY_MID && cmdIn.lbaHigh == KEY_HIGH;
    assign hlth = take && cmdIn.opcode == OP_HEALTH;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_sleep_decode: assert property (take && (cmdIn.opcode == OP_SLEEP_A ||
        cmdIn.opcode == OP_SLEEP_B) |=> flushReq) else $error("sleep not flushing");
    chk_sleep_only: assert property (hlth |=> linkActive [*8])
        else $error("slept on health command");
    chk_flush_first: assert property ($rose(spinDownReq) |-> $past(flushReq && flushDone))
        else $error("spin-down before flush");
    chk_idle_last: assert property ($fell(linkActive) |->
        $past(spinDownReq && spinDone || flushReq && flushDone && spindleStopped))
        else $error("link idled early");
    chk_skip_spin: assert property (flushReq && flushDone && spindleStopped
        |=> !spinDownReq [*2]) else $error("stopped spindle spun down");
    chk_stay_asleep: assert property (!linkActive && !softReset && !comReset
        |=> !linkActive) else $error("woke without reset");
    chk_attr_commit: assert property (hlth && keys && cmdIn.feature == SUB_READ_ATTR
        |=> commitReq) else $error("no commit");
    chk_thresh_fetch: assert property (hlth && keys && cmdIn.feature == SUB_READ_THRESH
        |=> fetchReq) else $error("no fetch");
    chk_bad_key: assert property (hlth && !keys |=> !commitReq && !fetchReq)
        else $error("bad key accepted");
    chk_word_held: assert property (dataValid && !dataTake
        |=> dataValid && $stable(dataWord)) else $error("word dropped");
    cover property (hlth && keys && cmdIn.feature == SUB_READ_ATTR);
    cover property ($fell(linkActive));
    cover property (dataValid && dataTake);
endmodule
bind dsh_cmd_core dsh_cmd_core_properties chk (.mclk(mclk), .resetn(resetn),
    .softReset(softReset), .comReset(comReset), .cmdValid(cmdValid), .cmdIn(cmdIn),
    .cmdReady(cmdReady), .flushReq(flushReq), .flushDone(flushDone),
    .spinDownReq(spinDownReq), .spinDone(spinDone), .spindleStopped(spindleStopped),
    .commitReq(commitReq), .commitDone(commitDone), .fetchReq(fetchReq),
    .fetchDone(fetchDone), .linkActive(linkActive), .dataValid(dataValid),
    .dataWord(dataWord), .dataTake(dataTake), .regReq(regReq), .regRdata(regRdata),
    .irq(irq));
`default_nettype wire

// >>> verif/dsh_mech_model.sv
// Drive mechanics model: cache, spindle and attribute sectors
`timescale 1ns/1ps
`default_nettype none
module dsh_mech_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic flushReq,
    input wire logic spinDownReq,
    input wire logic commitReq,
    input wire logic fetchReq,
    output logic flushDone,
    output logic spinDone,
    output logic commitDone,
    output logic fetchDone,
    output logic spindleStopped
);
    logic [3:0] reqs;
    logic [3:0] done;
    logic [3:0] cnt;
    logic [3:0] next_done;
    logic [3:0] next_cnt;
    logic next_stopped;
    assign reqs = {flushReq, spinDownReq, commitReq, fetchReq};
    assign {flushDone, spinDone, commitDone, fetchDone} = done;
    // Answer the pending request after one or seven cycles
    always_comb begin
        next_done = 4'h0;
        next_cnt = 4'h0;
        next_stopped = spindleStopped | done[2];
        if (reqs != 4'h0 && done == 4'h0) begin
            next_cnt = cnt + 4'h1;
            if (cnt == (slow ? 4'h6 : 4'h0)) begin
                next_done = reqs;
                next_cnt = 4'h0;
            end
        end
    end
    // State registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            done <= 4'h0;
            spindleStopped <= 1'b0;
        end else begin
            cnt <= next_cnt;
            done <= next_done;
            spindleStopped <= next_stopped;
        end
    end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the drive command block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsh_pkg::*;
    logic mclk, resetn, softReset, comReset, cmdValid, cmdReady, slow;
    logic flushReq, flushDone, spinDownReq, spinDone, spindleStopped;
    logic commitReq, commitDone, fetchReq, fetchDone, linkActive;
    logic dataValid, dataTake, irq;
    logic [15:0] dataWord;
    logic [31:0] regRdata, v;
    dsh_cmd_t cmdIn;
    dsh_reg_req_t regReq;
    int failures = 0;
    int num_checks = 0;
    dsh_cmd_core dut (.mclk(mclk), .resetn(resetn), .softReset(softReset),
        .comReset(comReset), .cmdValid(cmdValid), .cmdIn(cmdIn), .cmdReady(cmdReady),
        .flushReq(flushReq), .flushDone(flushDone), .spinDownReq(spinDownReq),
        .spinDone(spinDone), .spindleStopped(spindleStopped), .commitReq(commitReq),
        .commitDone(commitDone), .fetchReq(fetchReq), .fetchDone(fetchDone),
        .linkActive(linkActive), .dataValid(dataValid), .dataWord(dataWord),
        .dataTake(dataTake), .regReq(regReq), .regRdata(regRdata), .irq(irq));
    dsh_mech_model mech (.mclk(mclk), .resetn(resetn), .slow(slow), .flushReq(flushReq),
        .spinDownReq(spinDownReq), .commitReq(commitReq), .fetchReq(fetchReq),
        .flushDone(flushDone), .spinDone(spinDone), .commitDone(commitDone),
        .fetchDone(fetchDone), .spindleStopped(spindleStopped));
    // Clock, 10 ns period
    always #5 mclk = ~mclk;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq <= '0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq <= '0;
        #1 v = regRdata;
    endtask
    task automatic idle;
        int n = 0;
        while (cmdReady !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        chk(32'(cmdReady), 32'h1);
    endtask
    task automatic issue(input logic [7:0] op, f, m);
        idle();
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdIn <= '{opcode: op, feature: f, lbaMid: m, lbaHigh: KEY_HIGH};
        @(posedge mclk);
        cmdValid <= 1'b0;
        cmdIn <= '1;
        @(negedge mclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(ADDR_STATUS);
        chk(v & 32'hff, 32'(STATUS_RESET));
        rd(ADDR_ERROR);
        chk(v & 32'hff, 32'h0);
        rd(8'h40);
        chk(v, 32'h0);
        wr(8'h44, 32'hff);
        rd(ADDR_STATUS);
        chk(v & 32'hff, 32'(STATUS_RESET));
        chk(32'(irq), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_subs;
        logic [7:0] c[9] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdb};
        foreach (c[i]) begin
            issue(OP_HEALTH, c[i], KEY_MID);
            idle();
            rd(ADDR_ERROR);
            chk(32'(v[ERR_ABORT_BIT]), 32'h0);
        end
        issue(8'h37, SUB_READ_ATTR, KEY_MID);
        idle();
        chk(32'(linkActive), 32'h1);
        rd(ADDR_ERROR);
        chk(32'(v[ERR_ABORT_BIT]), 32'h0);
        $display("test subcommands done");
    endtask
    task automatic t_block(input logic sel);
        slow <= sel;
        wr(ADDR_IRQ_STAT, 32'h7);
        issue(OP_HEALTH, sel ? SUB_READ_THRESH : SUB_READ_ATTR, KEY_MID);
        repeat (40) if (dataValid !== 1'b1) @(negedge mclk);
        @(posedge mclk) dataTake <= 1'b1;
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            @(negedge mclk);
            chk(32'(dataValid), 32'h1);
            chk(32'(dataWord), {23'h0, sel, i[7:0]});
            @(posedge mclk) if (i == BLOCK_WORDS - 1) dataTake <= 1'b0;
        end
        idle();
        rd(ADDR_IRQ_STAT);
        chk(32'(v[IRQ_DONE_BIT]), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h7);
        $display("test block %0d done", sel);
    endtask
    task automatic t_abort;
        for (int i = 0; i < 3; i++) begin
            issue(OP_HEALTH, i == 0 ? 8'hd7 : i == 1 ? 8'hdc : SUB_READ_ATTR,
                i == 2 ? 8'h4e : KEY_MID);
            idle();
            rd(ADDR_ERROR);
            chk(32'(v[ERR_ABORT_BIT]), 32'h1);
            rd(ADDR_STATUS);
            chk(32'(v[ST_ERR_BIT]), 32'h1);
        end
        rd(ADDR_IRQ_STAT);
        chk(32'(v[IRQ_ABORT_BIT]), 32'h1);
        $display("test abort done");
    endtask
    task automatic t_irq;
        chk(32'(irq), 32'h1);
        wr(ADDR_IRQ_MASK, 32'h7);
        chk(32'(irq), 32'h0);
        rd(ADDR_IRQ_MASK);
        chk(v & 32'h7, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h7);
        rd(ADDR_IRQ_STAT);
        chk(v & 32'h7, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
    endtask
    task automatic t_sleep(input logic [7:0] op, input logic stopped);
        int n = 0;
        issue(op, 8'h0, 8'h0);
        while (linkActive === 1'b1 && n < 200) begin
            @(negedge mclk);
            if (stopped) chk(32'(spinDownReq), 32'h0);
            n++;
        end
        chk(32'(linkActive), 32'h0);
        repeat (16) @(negedge mclk);
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdIn <= '{opcode: OP_HEALTH, feature: SUB_READ_ATTR, lbaMid: KEY_MID, lbaHigh: KEY_HIGH};
        @(posedge mclk);
        cmdValid <= 1'b0;
        repeat (2) @(negedge mclk);
        chk(32'(commitReq), 32'h0);
        chk(32'(linkActive), 32'h0);
        chk(32'(cmdReady), 32'h0);
        chk(32'(irq), 32'h1);
        @(posedge mclk);
        softReset <= !stopped;
        comReset <= stopped;
        @(posedge mclk);
        softReset <= 1'b0;
        comReset <= 1'b0;
        repeat (8) @(negedge mclk);
        chk(32'(linkActive), 32'h1);
        wr(ADDR_IRQ_STAT, 32'h7);
        $display("test sleep %h done", op);
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        {softReset, comReset, cmdValid, dataTake, slow} = 5'h0;
        cmdIn = '0;
        regReq = '0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_subs();
        t_block(1'b0);
        t_block(1'b1);
        t_abort();
        t_irq();
        t_sleep(OP_SLEEP_A, 1'b0);
        t_sleep(OP_SLEEP_B, 1'b1);
        results();
    end
    initial begin
        #100us;
        failures++;
        results();
    end
endmodule
`default_nettype wire
